// >>> hw/psm_clk_switch.sv
// Glitch-free selector between two clock enable streams
module psm_clk_switch (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic sel,
   input  wire logic fast_tick,
   input  wire logic slow_tick,
   output logic      tick_q,
   output logic      on_slow_q
);
   logic pend_q;

   // Swap only on a tick of the new source, so no shortened period appears
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         on_slow_q <= 1'b0;
         pend_q    <= 1'b0;
      end else begin
         pend_q <= (sel != on_slow_q);
         if (pend_q && (sel ? slow_tick : fast_tick)) begin
            on_slow_q <= sel;
         end
      end
   end

   // Output tick follows the source currently owned
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= on_slow_q ? slow_tick : fast_tick;
      end
   end
endmodule

// >>> hw/psm_consts.svh
// Constants for the power save clock mode controller
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH
`define PSM_ADDR_CTRL      2'h0
`define PSM_ADDR_STATUS    2'h1
`define PSM_ADDR_PSAVE     2'h2
`define PSM_CTRL_RESET     8'h40
`define PSM_BIT_SLOW_ON    7
`define PSM_BIT_FAST_ON    6
`define PSM_BIT_DUAL_EN    5
`define PSM_BIT_CORE_SEL   4
`define PSM_BIT_RSVD       3
`define PSM_UP_HIGH        4'h4
`define PSM_UP_HD          4'hc
`define PSM_UP_DUAL        4'he
`define PSM_UP_DL          4'hf
`define PSM_UP_LOW         4'hb
`define PSM_PSAVE_IDLE     0
`define PSM_PSAVE_HALT     1
`endif

// >>> hw/psm_ctrl.sv
// Power save clock mode controller: mode register and clock gating
`include "psm_consts.svh"

// Contract
// - Reset loads the control register with 0x40, High Speed mode.
// - Bit 7 turns the slow oscillator on or off.
// - Bit 6 turns the fast oscillator on or off.
// - Bit 5 picks the idle timer clock: 0 fast, 1 slow.
// - Bit 4 picks the core clock: 0 fast, 1 slow.
// - Dual enable 0 with core select 1 forces Low Speed mode.
// - Bits 2 to 0 hold the idle timer window selection.
// - Upper nibble only 4, c, e, f, b in that order.
// - Writes to non-adjacent or illegal upper values are ignored.
// - Every operating mode offers HALT and IDLE.
// - HALT stops everything and needs the option bit.
// - IDLE keeps oscillator, idle timer and clock monitor running.
// - Power save keeps RAM, registers, I/O and other timers frozen.
module psm_ctrl
   import psm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata_q,
   input  wire logic       halt_option,
   input  wire logic       wake,
   input  wire logic       fast_osc_input,
   input  wire logic       slow_osc_input,
   output logic            slow_osc_on_q,
   output logic            fast_osc_on_q,
   output logic            core_tick_q,
   output logic            idle_tick_q,
   output logic            core_on_slow_q,
   output logic            idle_on_slow_q,
   output logic      [2:0] idle_window_q,
   output logic            idle_active_q,
   output logic            halt_active_q,
   output logic            osc_run_q,
   output logic            hold_q
);
   logic [7:0] ctrl_q;
   logic [1:0] fast_sync_q;
   logic [1:0] slow_sync_q;
   logic       fast_last_q;
   logic       slow_last_q;
   logic       fast_tick;
   logic       slow_tick;
   logic       core_sel;
   logic       idle_sel;
   logic       core_tick_w;
   logic       idle_tick_w;
   logic       core_slow_w;
   logic       idle_slow_w;
   psm_psave_t psave_q;

   // True when a nibble is one of the five legal codes
   function automatic logic legal_up(input logic [3:0] v);
      legal_up = (v == `PSM_UP_HIGH) || (v == `PSM_UP_HD) ||
                 (v == `PSM_UP_DUAL) || (v == `PSM_UP_DL) ||
                 (v == `PSM_UP_LOW);
   endfunction

   // Position of a legal nibble in the only valid sequence
   function automatic logic [2:0] seq_pos(input logic [3:0] v);
      unique case (v)
         `PSM_UP_HIGH: seq_pos = 3'h0;
         `PSM_UP_HD:   seq_pos = 3'h1;
         `PSM_UP_DUAL: seq_pos = 3'h2;
         `PSM_UP_DL:   seq_pos = 3'h3;
         default:      seq_pos = 3'h4;
      endcase
   endfunction

   // Adjacent or unchanged step inside the sequence
   function automatic logic step_ok(input logic [3:0] cur,
                                    input logic [3:0] nxt);
      logic [2:0] a;
      logic [2:0] b;
      a = seq_pos(cur);
      b = seq_pos(nxt);
      step_ok = legal_up(nxt) &&
                ((a == b) || (a == b + 3'h1) || (b == a + 3'h1));
   endfunction

   // Mode register; bad nibble steps leave it untouched
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= `PSM_CTRL_RESET;
      end else if (wr && addr == `PSM_ADDR_CTRL) begin
         if (step_ok(ctrl_q[7:4], wdata[7:4])) begin
            // Reserved bit kept at zero whatever software sends
            ctrl_q <= {wdata[7:4], 1'b0, wdata[2:0]};
         end
      end
   end

   // Power save entry from software, exit on wake, or from IDLE also on an idle timer tick
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         psave_q <= PSM_RUN;
      end else begin
         unique case (psave_q)
            PSM_RUN: begin
               if (wr && addr == `PSM_ADDR_PSAVE) begin
                  if (wdata[`PSM_PSAVE_HALT] && halt_option) begin
                     psave_q <= PSM_HALT;
                  end else if (wdata[`PSM_PSAVE_IDLE]) begin
                     psave_q <= PSM_IDLE;
                  end
               end
            end
            PSM_IDLE: begin
               if (wake || idle_tick_q) begin
                  psave_q <= PSM_RUN;
               end
            end
            PSM_HALT: begin
               if (wake) begin
                  psave_q <= PSM_RUN;
               end
            end
         endcase
      end
   end

   // Oscillator inputs come from pins: two stages before any use
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fast_sync_q <= 2'h0;
         slow_sync_q <= 2'h0;
         fast_last_q <= 1'b0;
         slow_last_q <= 1'b0;
      end else begin
         fast_sync_q <= {fast_sync_q[0], fast_osc_input};
         slow_sync_q <= {slow_sync_q[0], slow_osc_input};
         fast_last_q <= fast_sync_q[1];
         slow_last_q <= slow_sync_q[1];
      end
   end

   // Rising edges as enables; a stopped oscillator yields no ticks
   assign fast_tick = fast_sync_q[1] && !fast_last_q &&
                      ctrl_q[`PSM_BIT_FAST_ON] && psave_q != PSM_HALT;
   assign slow_tick = slow_sync_q[1] && !slow_last_q &&
                      ctrl_q[`PSM_BIT_SLOW_ON] && psave_q != PSM_HALT;

   // Invalid pair forces the slow idle timer clock as in Low Speed mode
   assign core_sel = ctrl_q[`PSM_BIT_CORE_SEL];
   assign idle_sel = ctrl_q[`PSM_BIT_DUAL_EN] ||
                     ctrl_q[`PSM_BIT_CORE_SEL];

   psm_clk_switch u_core_sw (
      .clk       (clk),
      .rstn      (rstn),
      .sel       (core_sel),
      .fast_tick (fast_tick),
      .slow_tick (slow_tick),
      .tick_q    (core_tick_w),
      .on_slow_q (core_slow_w)
   );

   psm_clk_switch u_idle_sw (
      .clk       (clk),
      .rstn      (rstn),
      .sel       (idle_sel),
      .fast_tick (fast_tick),
      .slow_tick (slow_tick),
      .tick_q    (idle_tick_w),
      .on_slow_q (idle_slow_w)
   );

   // Core ticks gated in any power save; idle timer runs except HALT
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         core_tick_q    <= 1'b0;
         idle_tick_q    <= 1'b0;
         core_on_slow_q <= 1'b0;
         idle_on_slow_q <= 1'b0;
      end else begin
         core_tick_q    <= core_tick_w && psave_q == PSM_RUN;
         idle_tick_q    <= idle_tick_w && psave_q != PSM_HALT;
         core_on_slow_q <= core_slow_w;
         idle_on_slow_q <= idle_slow_w;
      end
   end

   // Control and status outputs straight from flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slow_osc_on_q <= 1'b0;
         fast_osc_on_q <= 1'b1;
         idle_window_q <= 3'h0;
         idle_active_q <= 1'b0;
         halt_active_q <= 1'b0;
         osc_run_q     <= 1'b1;
         hold_q        <= 1'b0;
      end else begin
         slow_osc_on_q <= ctrl_q[`PSM_BIT_SLOW_ON];
         fast_osc_on_q <= ctrl_q[`PSM_BIT_FAST_ON];
         idle_window_q <= ctrl_q[2:0];
         idle_active_q <= psave_q == PSM_IDLE;
         halt_active_q <= psave_q == PSM_HALT;
         osc_run_q     <= psave_q != PSM_HALT;
         hold_q        <= psave_q != PSM_RUN;
      end
   end

   // Read port, data one cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            `PSM_ADDR_CTRL:   rdata_q <= ctrl_q;
            `PSM_ADDR_STATUS: rdata_q <= {4'h0, core_slow_w, idle_slow_w,
                                          psave_q == PSM_HALT,
                                          psave_q == PSM_IDLE};
            default:          rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // Checks
   reset_val_a: assert property (@(posedge clk)
      $rose(rstn) |-> ctrl_q == 8'h40)
      else $error("control not 0x40 after reset");
   legal_up_a: assert property (@(posedge clk) disable iff (!rstn)
      legal_up(ctrl_q[7:4]))
      else $error("illegal upper nibble");
   bad_step_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr && addr == 2'h0 && !step_ok(ctrl_q[7:4], wdata[7:4]))
      |=> $stable(ctrl_q))
      else $error("bad mode write took effect");
   rsvd_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      !ctrl_q[3])
      else $error("reserved bit set");
   slow_pin_a: assert property (@(posedge clk) disable iff (!rstn)
      ##1 slow_osc_on_q == $past(ctrl_q[7]))
      else $error("slow oscillator enable mismatch");
   fast_pin_a: assert property (@(posedge clk) disable iff (!rstn)
      ##1 fast_osc_on_q == $past(ctrl_q[6]))
      else $error("fast oscillator enable mismatch");
   halt_gate_a: assert property (@(posedge clk) disable iff (!rstn)
      (psave_q == PSM_HALT) |=> !idle_tick_q && !core_tick_q)
      else $error("tick during halt");
   halt_opt_a: assert property (@(posedge clk) disable iff (!rstn)
      (psave_q == PSM_RUN && !halt_option) |=> psave_q != PSM_HALT)
      else $error("halt without option");
   idle_core_a: assert property (@(posedge clk) disable iff (!rstn)
      (psave_q == PSM_IDLE) |=> !core_tick_q)
      else $error("core tick during idle");
   window_a: assert property (@(posedge clk) disable iff (!rstn)
      ##1 idle_window_q == $past(ctrl_q[2:0]))
      else $error("window select mismatch");
   c_dual_c: cover property (@(posedge clk) disable iff (!rstn)
      ctrl_q[7:4] == 4'he);
   c_low_c: cover property (@(posedge clk) disable iff (!rstn)
      ctrl_q[7:4] == 4'hb);
   c_idle_c: cover property (@(posedge clk) disable iff (!rstn)
      psave_q == PSM_IDLE ##1 psave_q == PSM_RUN);
   c_halt_c: cover property (@(posedge clk) disable iff (!rstn)
      psave_q == PSM_HALT ##1 psave_q == PSM_RUN);
   c_swap_c: cover property (@(posedge clk) disable iff (!rstn)
      $rose(core_on_slow_q));

   // Power save exits, and what keeps running meanwhile
   wake_run_a: assert property (@(posedge clk) disable iff (!rstn)
      (psave_q == PSM_HALT && wake) |=> psave_q == PSM_RUN)
      else $error("halt not left on wake");
   idle_out_a: assert property (@(posedge clk) disable iff (!rstn)
      (psave_q == PSM_IDLE && (wake || idle_tick_q)) |=> psave_q == PSM_RUN)
      else $error("idle not left on wake or timer");
   idle_osc_a: assert property (@(posedge clk) disable iff (!rstn)
      (psave_q == PSM_IDLE) |=> osc_run_q && hold_q)
      else $error("oscillator stopped in idle");
   halt_off_a: assert property (@(posedge clk) disable iff (!rstn)
      (psave_q == PSM_HALT) |=> !osc_run_q && hold_q)
      else $error("halt did not freeze");

   // Switches: single pulses, and a swap only on a tick of the new source
   core_gap_a: assert property (@(posedge clk) disable iff (!rstn)
      core_tick_q |=> !core_tick_q)
      else $error("core pulses back to back");
   idle_gap_a: assert property (@(posedge clk) disable iff (!rstn)
      idle_tick_q |=> !idle_tick_q)
      else $error("idle pulses back to back");
   to_slow_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(core_slow_w) |-> $past(slow_tick))
      else $error("core swapped to slow off a tick");
   to_fast_a: assert property (@(posedge clk) disable iff (!rstn)
      $fell(core_slow_w) |-> $past(fast_tick))
      else $error("core swapped to fast off a tick");
   idle_slow_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(idle_slow_w) |-> $past(slow_tick))
      else $error("idle swapped to slow off a tick");
endmodule

// >>> hw/psm_pkg.sv
// Types for the power save clock mode controller
package psm_pkg;
   typedef enum logic [1:0] {
      PSM_RUN,
      PSM_IDLE,
      PSM_HALT
   } psm_psave_t;
   typedef enum logic [2:0] {
      PSM_MODE_HIGH,
      PSM_MODE_HD,
      PSM_MODE_DUAL,
      PSM_MODE_DL,
      PSM_MODE_LOW
   } psm_mode_t;
endpackage

// >>> tb/power_save_clock_mode_ctrl_test.sv
// Self-checking bench for the power save clock mode controller
module power_save_clock_mode_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import psm_pkg::*;

   logic       clk;
   logic       rstn;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata_q;
   logic       halt_option;
   logic       wake;
   logic       fast_osc_input;
   logic       slow_osc_input;
   logic       slow_osc_on_q;
   logic       fast_osc_on_q;
   logic       core_tick_q;
   logic       idle_tick_q;
   logic       core_on_slow_q;
   logic       idle_on_slow_q;
   logic [2:0] idle_window_q;
   logic       idle_active_q;
   logic       halt_active_q;
   logic       osc_run_q;
   logic       hold_q;
   logic       fast_en;
   logic       last_tick = 1'b0;
   int         bad_count;
   int         total_checks;
   int         tick_count = 0;
   int         tick_base;
   logic [7:0] got;
   logic [7:0] steps [12][2];

   psm_ctrl psm_ctrl_i (
      .clk            (clk),
      .rstn           (rstn),
      .addr           (addr),
      .wdata          (wdata),
      .wr             (wr),
      .rd             (rd),
      .rdata_q        (rdata_q),
      .halt_option    (halt_option),
      .wake           (wake),
      .fast_osc_input (fast_osc_input),
      .slow_osc_input (slow_osc_input),
      .slow_osc_on_q  (slow_osc_on_q),
      .fast_osc_on_q  (fast_osc_on_q),
      .core_tick_q    (core_tick_q),
      .idle_tick_q    (idle_tick_q),
      .core_on_slow_q (core_on_slow_q),
      .idle_on_slow_q (idle_on_slow_q),
      .idle_window_q  (idle_window_q),
      .idle_active_q  (idle_active_q),
      .halt_active_q  (halt_active_q),
      .osc_run_q      (osc_run_q),
      .hold_q         (hold_q)
   );

   // Bench clock and two unrelated oscillator pins
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Fast pin toggles every 8.3 ns while fast_en is set; slow pin toggles every 101 ns throughout
   always #8.3 if (fast_en) fast_osc_input = ~fast_osc_input;
   always #101 slow_osc_input = ~slow_osc_input;

   task automatic tally_and_finish();
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle strobes, changed just after the edge
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata_q;
   endtask

   // Switch waits for a tick of the new source, so the wait is bounded
   task automatic wait_src(input logic core, input logic v);
      int n;
      for (n = 0; n < 400; n++) begin
         if ((core ? core_on_slow_q : idle_on_slow_q) === v) break;
         @(posedge clk);
         #1;
      end
      if (n == 400) begin
         bad_count++;
         tally_and_finish();
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Core ticks in halt, and no back-to-back core pulses after a switch
   always @(negedge clk) begin
      if (core_tick_q === 1'b1 && last_tick === 1'b1) begin
         check(8'h01, 8'h00);
      end
      if (core_tick_q === 1'b1) tick_count <= tick_count + 1;
      last_tick <= core_tick_q;
   end

   initial begin
      rstn = 1'b0; addr = 2'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
      halt_option = 1'b0; wake = 1'b0; fast_en = 1'b1;
      fast_osc_input = 1'b0; slow_osc_input = 1'b0;
      bad_count = 0; total_checks = 0;
      // Written value, then readback; dual to high in two writes
      steps = '{'{8'he0, 8'h40}, '{8'h50, 8'h40}, '{8'hc8, 8'hc0},
                '{8'he5, 8'he5}, '{8'h45, 8'he5}, '{8'hf2, 8'hf2},
                '{8'hb7, 8'hb7}, '{8'he0, 8'hb7}, '{8'hf1, 8'hf1},
                '{8'he2, 8'he2}, '{8'hc0, 8'hc0}, '{8'h40, 8'h40}};
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(2'h0, got);
      check(got, 8'h40);
      check(8'(fast_osc_on_q), 8'h01);
      check(8'(slow_osc_on_q), 8'h00);
      // Walk the mode ladder, including skipped and illegal steps
      foreach (steps[i]) begin
         wr_reg(2'h0, steps[i][0]);
         rd_reg(2'h0, got);
         check(got, steps[i][1]);
         cycles(1);
         check(8'(slow_osc_on_q), 8'(steps[i][1][7]));
         check(8'(fast_osc_on_q), 8'(steps[i][1][6]));
         check(8'(idle_window_q), 8'(steps[i][1][2:0]));
         wait_src(1'b0, steps[i][1][5]);
         check(8'(idle_on_slow_q), 8'(steps[i][1][5]));
         wait_src(1'b1, steps[i][1][4]);
         check(8'(core_on_slow_q), 8'(steps[i][1][4]));
      end
      // Idle with the fast pin quiet and drained, so only wake ends it
      fast_en = 1'b0;
      cycles(8);
      wr_reg(2'h0, 8'h40);
      wr_reg(2'h2, 8'h01);
      cycles(2);
      check({5'h0, idle_active_q, hold_q, osc_run_q}, 8'h07);
      rd_reg(2'h1, got);
      check(got, 8'h01);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      cycles(2);
      check(8'(idle_active_q), 8'h00);
      // Halt refused without the option bit
      wr_reg(2'h2, 8'h02);
      cycles(2);
      check({6'h0, halt_active_q, idle_active_q}, 8'h00);
      // Halt with the option: no core ticks, oscillator stopped
      @(posedge clk);
      halt_option <= 1'b1;
      wr_reg(2'h2, 8'h02);
      fast_en = 1'b1;
      cycles(2);
      check({5'h0, halt_active_q, osc_run_q, hold_q}, 8'h05);
      tick_base = tick_count;
      cycles(40);
      check(8'(tick_count - tick_base), 8'h00);
      check(8'(idle_tick_q), 8'h00);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      cycles(2);
      check({6'h0, halt_active_q, osc_run_q}, 8'h01);
      // Idle with the fast pin running ends on an idle timer tick
      wr_reg(2'h2, 8'h01);
      got = 8'h01;
      for (int k = 0; k < 40 && got != 8'h00; k++) begin
         @(posedge clk);
         #1 got = 8'(idle_active_q);
      end
      check(got, 8'h00);
      rd_reg(2'h0, got);
      check(got, 8'h40);
      tally_and_finish();
   end
endmodule
